// ===== src/oscsw_pkg.sv
// Package: register map, field positions, reset values and codes for the oscillator control
package oscsw_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OSC_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] RC_TUNE_ADDR = 8'h04;
  localparam logic [7:0] RC_TUNE_TWO_ADDR = 8'h08;
  localparam logic [7:0] DITHER_SHIFT_ADDR = 8'h0C;
  localparam logic [7:0] UNLOCK_LOW_ADDR = 8'h10;
  localparam logic [7:0] UNLOCK_HIGH_ADDR = 8'h14;
  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int ACTIVE_LSB = 12;
  localparam int REQ_LSB = 8;
  localparam int LOCK_CFG_BIT = 7;
  localparam int PLL_LOCK_BIT = 5;
  localparam int DITHER_BIT = 4;
  localparam int FAIL_BIT = 3;
  localparam int TSEQ_BIT = 2;
  localparam int SWITCH_BIT = 0;
  // Writable bits of the control register (bits 15, 11, 6, 1 unimplemented)
  localparam logic [15:0] CTRL_WMASK = 16'h07BD;
  // ----------------------------------------------------------------
  // Unlock keys and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_LOW_1 = 8'h46;
  localparam logic [7:0] KEY_LOW_2 = 8'h57;
  localparam logic [7:0] KEY_HIGH_1 = 8'h78;
  localparam logic [7:0] KEY_HIGH_2 = 8'h9A;
  localparam logic [15:0] TUNE_RESET = 16'h0000;
  localparam logic [14:0] SHIFT_RESET = 15'h0000;
  localparam logic [14:0] SHIFT_SEED = 15'h0001;
  // ----------------------------------------------------------------
  // Oscillator group codes
  // ----------------------------------------------------------------
  localparam logic [2:0] GRP_FRC = 3'h0;
  localparam logic [2:0] GRP_FRC_PLL = 3'h1;
  localparam logic [2:0] GRP_PRI = 3'h2;
  localparam logic [2:0] GRP_PRI_PLL = 3'h3;
  typedef enum logic [1:0] {KEY_IDLE, KEY_ONE, KEY_OPEN} oscsw_key_t;
endpackage : oscsw_pkg

// ===== src/oscsw_top.sv
// Oscillator switch control, fail flag, PLL lock status and fast RC trim with dither
// Function
// RL1 - Read-only active group field, 3-bit code
// RL2 - Reset forces active group to fast RC
// RL3 - Successful switch copies requested into active
// RL4 - Clock failure forces active group to fast RC
// RL5 - Writable requested group at bits 10-8
// RL6 - Lock and switching-disable refuse config changes
// RL7 - Lock bit cannot be cleared by software
// RL8 - PLL lock flag clear, set rules
// RL9 - Lock flag reads zero without PLL
// RL10 - Dither applied only while enabled
// RL11 - Fail flag set, cleared, software clearable
// RL12 - Sequencer uses base and seven sequence fields
// RL13 - Roll index n selects sequence field n
// RL14 - Switch request bit and its hardware clears
// RL15 - Tune values are two's complement
// RL16 - Fifteen-bit shift register, bit 15 zero
// RL17 - Unimplemented control bits read zero
// RL18 - Reset source from configuration bits
// RL19 - Low byte unlocked by 46h then 57h
// RL20 - High byte unlocked by 78h then 9Ah
// RL21 - Switching and monitor config decoding
// RL22 - Roll index zero uses base tune
// RL23 - Redundant switch clears request only
// RL24 - Shift register advances each dither step
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ns
module oscsw_top (
  input wire logic REF_CLK, // System clock, 20 MHz
  input wire logic RST_B, // Synchronous reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction
  input wire logic [7:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  input wire logic [3:0] PSTRB, // APB byte strobes
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  input wire logic [1:0] INIT_GROUP_CFG, // Power-on group configuration
  input wire logic [1:0] SWITCH_MONITOR_CFG, // Switching/monitor configuration
  input wire logic CLOCK_FAIL, // Monitor failure detect, async
  input wire logic PLL_LOCK_IN, // PLL lock indication, async
  input wire logic SWITCH_DONE, // Clock switch completed, async
  input wire logic DITHER_STEP, // Dither step strobe, same domain
  input wire logic [2:0] ROLL_INDEX, // Roll index from the PWM, same domain
  output logic [2:0] ACTIVE_GROUP, // Current oscillator group
  output logic [2:0] TARGET_GROUP, // Group requested for switching
  output logic SWITCH_GO, // Switch request to the clock switcher
  output logic MONITOR_EN, // Fail-safe monitor enabled
  output logic [3:0] RC_TRIM, // Fast RC trim, two's complement
  output logic [14:0] DITHER_TRIM // Pseudo-random trim perturbation
);
  import oscsw_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0] active_group;
  logic [2:0] requested_group;
  logic config_lock, pll_locked, dither_enable, clock_fail_flag;
  logic tune_sequencer_enable, switch_request, init_done;
  logic [15:0] rc_tune_reg, rc_tune_reg_two;
  logic [14:0] dither_shift_reg;
  logic [3:0] rc_trim_q;
  oscsw_key_t key_low, key_high;
  logic [2:0] fail_s, lock_s, done_s;
  logic fail_prev;

  // Input synchronisers, first stage read only by second
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      fail_s <= 3'h0;
      lock_s <= 3'h0;
      done_s <= 3'h0;
      fail_prev <= 1'b0;
    end else begin
      fail_s <= {fail_s[1:0], CLOCK_FAIL};
      lock_s <= {lock_s[1:0], PLL_LOCK_IN};
      done_s <= {done_s[1:0], SWITCH_DONE};
      fail_prev <= fail_s[1];
    end
  end

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire switch_disabled = SWITCH_MONITOR_CFG[1]; // [RL21]
  wire monitor_on = (SWITCH_MONITOR_CFG == 2'b00); // [RL21]
  wire cfg_locked = config_lock & switch_disabled; // [RL6]
  wire fail_event = monitor_on & fail_s[1] & ~fail_prev;
  wire done_pulse = done_s[1] & ~done_s[2];
  wire uses_pll = (active_group == GRP_FRC_PLL) | (active_group == GRP_PRI_PLL);
  wire apb_setup = PSEL & ~PENABLE;
  wire acc = PSEL & PENABLE;
  wire wr = acc & PWRITE;
  wire hit_ctrl = (PADDR == OSC_CONTROL_ADDR);
  wire hit_tun = (PADDR == RC_TUNE_ADDR);
  wire hit_tun2 = (PADDR == RC_TUNE_TWO_ADDR);
  wire hit_shift = (PADDR == DITHER_SHIFT_ADDR);
  wire hit_ul = (PADDR == UNLOCK_LOW_ADDR);
  wire hit_uh = (PADDR == UNLOCK_HIGH_ADDR);
  wire mapped = hit_ctrl | hit_tun | hit_tun2 | hit_shift | hit_ul | hit_uh;
  // Control byte writes pass only inside the one-access key window
  wire ctl_lo_wr = wr & hit_ctrl & PSTRB[0] & (key_low == KEY_OPEN); // [RL19]
  wire ctl_hi_wr = wr & hit_ctrl & PSTRB[1] & (key_high == KEY_OPEN); // [RL20]
  // A valid switch starts when the request is newly set to a new group
  wire sw_write = ctl_lo_wr & PWDATA[SWITCH_BIT] & ~switch_request & ~switch_disabled
                  & ~cfg_locked;
  wire next_req_grp_sel = ctl_hi_wr & ~cfg_locked; // [RL6]
  wire [2:0] req_after = next_req_grp_sel ? PWDATA[REQ_LSB +: 3] : requested_group;
  wire redundant = sw_write & (req_after == active_group); // [RL23]
  wire sw_start = sw_write & ~redundant;

  // Key sequencer for one byte lane
  function automatic oscsw_key_t key_next(input oscsw_key_t cur, input logic lane_wr,
                                          input logic [7:0] d, input logic [7:0] k1,
                                          input logic [7:0] k2, input logic any_acc);
    oscsw_key_t n;
    n = cur;
    if (any_acc) begin
      if (lane_wr && d == k1 && cur != KEY_ONE) begin
        n = KEY_ONE;
      end else if (lane_wr && d == k2 && cur == KEY_ONE) begin
        n = KEY_OPEN;
      end else begin
        n = KEY_IDLE;
      end
    end
    return n;
  endfunction : key_next

  wire oscsw_key_t next_key_low = key_next(key_low, wr & hit_ul & PSTRB[0], PWDATA[7:0],
                                           KEY_LOW_1, KEY_LOW_2, acc); // [RL19]
  wire oscsw_key_t next_key_high = key_next(key_high, wr & hit_uh & PSTRB[0], PWDATA[7:0],
                                            KEY_HIGH_1, KEY_HIGH_2, acc); // [RL20]

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      active_group <= GRP_FRC; // [RL2]
      requested_group <= GRP_FRC;
      config_lock <= 1'b0;
      pll_locked <= 1'b0;
      dither_enable <= 1'b0;
      clock_fail_flag <= 1'b0;
      tune_sequencer_enable <= 1'b0;
      switch_request <= 1'b0;
      init_done <= 1'b0;
      key_low <= KEY_IDLE;
      key_high <= KEY_IDLE;
    end else begin
      key_low <= next_key_low;
      key_high <= next_key_high;
      init_done <= 1'b1;
      // Configuration strap loaded after reset release
      if (!init_done) begin
        requested_group <= {1'b0, INIT_GROUP_CFG}; // [RL5] [RL18]
        active_group <= {1'b0, INIT_GROUP_CFG}; // [RL18]
      end else if (next_req_grp_sel) begin
        requested_group <= PWDATA[REQ_LSB +: 3]; // [RL5]
      end
      if (ctl_lo_wr) begin
        if (PWDATA[LOCK_CFG_BIT]) begin
          config_lock <= 1'b1; // [RL7]
        end
        dither_enable <= PWDATA[DITHER_BIT];
        tune_sequencer_enable <= PWDATA[TSEQ_BIT];
      end
      // Switch request: set by software, cleared by hardware
      if (fail_event || redundant || (switch_request && done_pulse)) begin
        switch_request <= 1'b0; // [RL14] [RL23]
      end else if (sw_start) begin
        switch_request <= 1'b1; // [RL14]
      end
      if (init_done && fail_event) begin
        active_group <= GRP_FRC; // [RL4]
      end else if (init_done && switch_request && done_pulse) begin
        active_group <= requested_group; // [RL3]
      end
      // Fail flag: set wins over software and start clears
      if (fail_event) begin
        clock_fail_flag <= 1'b1; // [RL11]
      end else if (sw_start || (ctl_lo_wr && !PWDATA[FAIL_BIT])) begin
        clock_fail_flag <= 1'b0; // [RL11]
      end
      // PLL lock flag
      if (sw_start || !lock_s[1]) begin
        pll_locked <= 1'b0; // [RL8]
      end else begin
        pll_locked <= 1'b1; // [RL8]
      end
    end
  end

  // ----------------------------------------------------------------
  // Tune and dither registers
  // ----------------------------------------------------------------
  wire tun_wr = wr & hit_tun & ~cfg_locked;
  wire tun2_wr = wr & hit_tun2 & ~cfg_locked;
  wire shift_wr = wr & hit_shift;
  wire shift_fb = dither_shift_reg[14] ^ dither_shift_reg[13];
  wire [14:0] shift_adv = (dither_shift_reg == SHIFT_RESET) ? SHIFT_SEED
                          : {dither_shift_reg[13:0], shift_fb};

  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : lane_merge

  wire [15:0] shift_wval = lane_merge({1'b0, dither_shift_reg}, PWDATA, PSTRB);

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      rc_tune_reg <= TUNE_RESET;
      rc_tune_reg_two <= TUNE_RESET;
      dither_shift_reg <= SHIFT_RESET;
    end else begin
      if (tun_wr) begin
        rc_tune_reg <= lane_merge(rc_tune_reg, PWDATA, PSTRB);
      end
      if (tun2_wr) begin
        rc_tune_reg_two <= lane_merge(rc_tune_reg_two, PWDATA, PSTRB);
      end
      if (shift_wr) begin
        dither_shift_reg <= shift_wval[14:0]; // [RL16]
      end else if (dither_enable && DITHER_STEP) begin
        dither_shift_reg <= shift_adv; // [RL24]
      end
    end
  end

  // ----------------------------------------------------------------
  // Trim selection
  // ----------------------------------------------------------------
  wire [31:0] tune_all = {rc_tune_reg_two, rc_tune_reg};
  wire use_seq = tune_sequencer_enable & (ROLL_INDEX != 3'h0); // [RL12] [RL22]
  wire [3:0] next_trim = use_seq ? tune_all[{ROLL_INDEX, 2'b00} +: 4]
                                 : rc_tune_reg[3:0]; // [RL13] [RL15]

  // Registered fast RC trim output
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      rc_trim_q <= 4'h0;
    end else begin
      rc_trim_q <= next_trim;
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  wire [15:0] ctrl_read = {1'b0, active_group, 1'b0, requested_group, config_lock, 1'b0,
                           pll_locked & uses_pll, dither_enable, clock_fail_flag,
                           tune_sequencer_enable, 1'b0, switch_request}; // [RL1] [RL9] [RL17]
  wire [15:0] rd_mux = hit_ctrl ? (ctrl_read & (CTRL_WMASK | 16'h7028))
                     : hit_tun ? rc_tune_reg
                     : hit_tun2 ? rc_tune_reg_two
                     : hit_shift ? {1'b0, dither_shift_reg} // [RL16]
                     : 16'h0000;

  // Read data captured in setup, held otherwise
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      PRDATA <= 32'h0000_0000;
    end else if (apb_setup && !PWRITE) begin
      PRDATA <= {16'h0000, rd_mux};
    end
  end

  assign PREADY = 1'b1;
  assign PSLVERR = acc & ~mapped;
  assign ACTIVE_GROUP = active_group;
  assign TARGET_GROUP = requested_group;
  assign SWITCH_GO = switch_request;
  assign MONITOR_EN = monitor_on;
  assign RC_TRIM = rc_trim_q;
  assign DITHER_TRIM = dither_enable ? dither_shift_reg : 15'h0000; // [RL10]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_lock_sticky: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    config_lock |=> config_lock) else $error("lock bit cleared"); // [RL7]
  a_fail_to_frc: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    init_done && fail_event |=> active_group == GRP_FRC && !switch_request
    && clock_fail_flag) else $error("fail did not force fast RC"); // [RL4]
  a_switch_copy: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    init_done && !fail_event && switch_request && done_pulse
    |=> active_group == $past(requested_group) && !switch_request)
    else $error("switch completion wrong"); // [RL3]
  a_redundant_keep: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    redundant && !fail_event |=> !switch_request && $stable(active_group))
    else $error("redundant switch misbehaved"); // [RL23]
  a_locked_ro: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    init_done && cfg_locked |=> $stable(requested_group))
    else $error("locked config changed"); // [RL6]
  a_pll_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !uses_pll |-> ctrl_read[PLL_LOCK_BIT] == 1'b0)
    else $error("lock flag without pll"); // [RL9]
  a_no_dither: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !dither_enable |-> DITHER_TRIM == 15'h0000) else $error("dither while off"); // [RL10]
  a_roll_select: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !tune_sequencer_enable || ROLL_INDEX == 3'h0 |=> RC_TRIM == $past(rc_tune_reg[3:0]))
    else $error("base trim not used"); // [RL12]
  a_key_window: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    key_low == KEY_OPEN && acc |=> key_low != KEY_OPEN)
    else $error("unlock window too long"); // [RL19]

  // ----------------------------------------------------------------
  // Field update checks
  // ----------------------------------------------------------------
  // Requested group follows a keyed high byte write
  a_req_write: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL5]
    init_done && next_req_grp_sel |=> requested_group == $past(PWDATA[REQ_LSB +: 3]))
    else $error("requested group not written");
  // Strap loads the groups right after reset release
  a_group_strap: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL18]
    !init_done |=> active_group == {1'b0, $past(INIT_GROUP_CFG)})
    else $error("strap group not loaded");
  // Switch start drops the lock flag
  a_pll_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL8]
    sw_start |=> !pll_locked)
    else $error("lock flag kept on start");
  // Switch start clears the fail flag unless a failure arrives
  a_fail_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL11]
    sw_start && !fail_event |=> !clock_fail_flag)
    else $error("fail flag kept on start");
  // Valid switch start raises the request
  a_switch_set: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL14]
    sw_start && !fail_event |=> switch_request)
    else $error("request not raised");
  // Switching disabled never raises a request
  a_no_start_off: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL21]
    switch_disabled && !switch_request |=> !switch_request)
    else $error("request while switching off");
  // Monitor is off whenever switching is disabled
  a_monitor_cfg: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL21]
    SWITCH_MONITOR_CFG[1] |-> !MONITOR_EN)
    else $error("monitor on while disabled");

  // ----------------------------------------------------------------
  // Trim, dither and key checks
  // ----------------------------------------------------------------
  // Roll index seven picks the top sequence field
  a_seq_pick: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL13]
    tune_sequencer_enable && ROLL_INDEX == 3'h7 |=> RC_TRIM == $past(rc_tune_reg_two[15:12]))
    else $error("sequence field not used");
  // One dither step from a value of one gives two
  a_shift_step: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL24]
    dither_enable && DITHER_STEP && !shift_wr && dither_shift_reg == 15'h0001
    |=> dither_shift_reg == 15'h0002)
    else $error("shift register did not step");
  // Dither output follows the shift register while enabled
  a_dither_follow: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL10]
    dither_enable |-> DITHER_TRIM == dither_shift_reg)
    else $error("dither trim wrong");
  // Shift register reads back with its top bit clear
  a_shift_msb: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL16]
    apb_setup && !PWRITE && hit_shift |=> PRDATA[31:15] == 17'h00000)
    else $error("shift top bit set");
  // High byte window lasts a single access
  a_high_window: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL20]
    key_high == KEY_OPEN && acc |=> key_high != KEY_OPEN)
    else $error("high unlock window too long");

  // ----------------------------------------------------------------
  // Scenario covers
  // ----------------------------------------------------------------
  c_redundant: cover property (@(posedge REF_CLK) disable iff (!RST_B) redundant);
  c_locked: cover property (@(posedge REF_CLK) disable iff (!RST_B) cfg_locked);
  c_switch: cover property (@(posedge REF_CLK) disable iff (!RST_B)
    switch_request && done_pulse);
  c_fail: cover property (@(posedge REF_CLK) disable iff (!RST_B) fail_event);
  c_seq_trim: cover property (@(posedge REF_CLK) disable iff (!RST_B) use_seq);
endmodule : oscsw_top

// ===== tb/tb_top.sv
// Self-checking bench for the oscillator switch control and fast RC trim block
`timescale 1ns/1ns
module tb_top;
  import oscsw_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus signals and design instance
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [1:0] init_cfg = 2'h0, sw_cfg = 2'h0;
  logic clock_fail = 1'b0, pll_lock_in = 1'b0, switch_done = 1'b0, dither_step = 1'b0;
  logic [2:0] roll_index = 3'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, switch_go, monitor_en;
  logic [2:0] active_group, target_group;
  logic [3:0] rc_trim;
  logic [14:0] dither_trim;
  int fails = 0;
  int checks = 0;
  oscsw_top oscsw_top_inst (.REF_CLK(ref_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .INIT_GROUP_CFG(init_cfg), .SWITCH_MONITOR_CFG(sw_cfg),
    .CLOCK_FAIL(clock_fail), .PLL_LOCK_IN(pll_lock_in), .SWITCH_DONE(switch_done),
    .DITHER_STEP(dither_step), .ROLL_INDEX(roll_index), .ACTIVE_GROUP(active_group),
    .TARGET_GROUP(target_group), .SWITCH_GO(switch_go), .MONITOR_EN(monitor_en),
    .RC_TRIM(rc_trim), .DITHER_TRIM(dither_trim));
  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) chk("pready", 32'h1, 32'h0);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(what, exp, rdat);
  endtask : rdchk
  // Keyed writes to the control low and high bytes
  task automatic wr_low(input logic [7:0] v);
    apb(1'b1, UNLOCK_LOW_ADDR, {24'h0, KEY_LOW_1}, 4'h1);
    apb(1'b1, UNLOCK_LOW_ADDR, {24'h0, KEY_LOW_2}, 4'h1);
    apb(1'b1, OSC_CONTROL_ADDR, {24'h0, v}, 4'h1);
  endtask : wr_low
  task automatic wr_high(input logic [7:0] v);
    apb(1'b1, UNLOCK_HIGH_ADDR, {24'h0, KEY_HIGH_1}, 4'h1);
    apb(1'b1, UNLOCK_HIGH_ADDR, {24'h0, KEY_HIGH_2}, 4'h1);
    apb(1'b1, OSC_CONTROL_ADDR, {16'h0, v, 8'h00}, 4'h2);
  endtask : wr_high
  // Waits, bounded, for the switch request to drop
  task automatic wait_go_low();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (switch_go !== 1'b0 && n < 20);
    chk("switch latency", 32'h1, 32'(n <= 6));
  endtask : wait_go_low
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic report_and_stop();
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(5);
    chk("active in reset", 32'h0, 32'(active_group));
    rst_b <= 1'b1;
    cyc(1);
    rdchk("control reset", OSC_CONTROL_ADDR, 32'h0);
    rdchk("shift reset", DITHER_SHIFT_ADDR, 32'h0);
    apb(1'b0, 8'h18, 32'h0, 4'h0);
    chk("unmapped error", 32'h1, 32'(rerr));
    apb(1'b1, OSC_CONTROL_ADDR, 32'hFFFF, 4'h3);
    rdchk("unkeyed write", OSC_CONTROL_ADDR, 32'h0);
    apb(1'b1, UNLOCK_LOW_ADDR, {24'h0, KEY_LOW_1}, 4'h1);
    apb(1'b0, RC_TUNE_ADDR, 32'h0, 4'h0);
    apb(1'b1, UNLOCK_LOW_ADDR, {24'h0, KEY_LOW_2}, 4'h1);
    apb(1'b1, OSC_CONTROL_ADDR, 32'h10, 4'h1);
    rdchk("broken keys", OSC_CONTROL_ADDR, 32'h0);
    wr_high(8'hFF);
    rdchk("high byte", OSC_CONTROL_ADDR, 32'h0700);
    wr_high({5'h0, GRP_PRI});
    wr_low(8'h01);
    cyc(1);
    chk("request set", 32'h1, 32'(switch_go));
    chk("target group", 32'(GRP_PRI), 32'(target_group));
    switch_done <= 1'b1;
    wait_go_low();
    switch_done <= 1'b0;
    chk("active primary", 32'(GRP_PRI), 32'(active_group));
    wr_low(8'h01);
    cyc(3);
    chk("redundant request", 32'h0, 32'(switch_go));
    pll_lock_in <= 1'b1;
    cyc(4);
    rdchk("lock without pll", OSC_CONTROL_ADDR, 32'h2200);
    wr_high({5'h0, GRP_PRI_PLL});
    wr_low(8'h01);
    switch_done <= 1'b1;
    wait_go_low();
    switch_done <= 1'b0;
    cyc(4);
    rdchk("pll locked", OSC_CONTROL_ADDR, 32'h3320);
    pll_lock_in <= 1'b0;
    cyc(4);
    rdchk("pll lost", OSC_CONTROL_ADDR, 32'h3300);
    for (int n = 0; n < 4; n++) begin
      sw_cfg <= n[1:0];
      cyc(1);
      chk("monitor enable", 32'(n == 0), 32'(monitor_en));
    end
    sw_cfg <= 2'h0;
    wr_high({5'h0, GRP_PRI});
    wr_low(8'h01);
    clock_fail <= 1'b1;
    wait_go_low();
    clock_fail <= 1'b0;
    chk("fail active", 32'(GRP_FRC), 32'(active_group));
    rdchk("fail flag", OSC_CONTROL_ADDR, 32'h0208);
    wr_low(8'h00);
    rdchk("fail cleared", OSC_CONTROL_ADDR, 32'h0200);
    apb(1'b1, RC_TUNE_ADDR, 32'h4321, 4'hF);
    apb(1'b1, RC_TUNE_TWO_ADDR, 32'h8765, 4'hF);
    for (int n = 0; n < 8; n++) begin
      roll_index <= n[2:0];
      cyc(2);
      chk("base trim", 32'h1, 32'(rc_trim));
    end
    wr_low(8'h04);
    for (int n = 0; n < 8; n++) begin
      roll_index <= n[2:0];
      cyc(2);
      chk("seq trim", (n == 0) ? 32'h1 : 32'(n + 1), 32'(rc_trim));
    end
    chk("dither off", 32'h0, 32'(dither_trim));
    apb(1'b1, DITHER_SHIFT_ADDR, 32'hFFFF, 4'h3);
    rdchk("shift width", DITHER_SHIFT_ADDR, 32'h7FFF);
    apb(1'b1, DITHER_SHIFT_ADDR, 32'h0001, 4'h3);
    wr_low(8'h10);
    cyc(1);
    chk("dither on", 32'h1, 32'(dither_trim));
    dither_step <= 1'b1;
    cyc(1);
    dither_step <= 1'b0;
    cyc(2);
    apb(1'b0, DITHER_SHIFT_ADDR, 32'h0, 4'h0);
    chk("shift advanced", 32'h2, rdat);
    chk("dither trim", rdat, 32'(dither_trim));
    wr_low(8'h00);
    cyc(1);
    chk("dither stopped", 32'h0, 32'(dither_trim));
    sw_cfg <= 2'h2;
    wr_low(8'h80);
    wr_low(8'h00);
    rdchk("lock stays", OSC_CONTROL_ADDR, 32'h0280);
    apb(1'b1, RC_TUNE_ADDR, 32'h1111, 4'hF);
    rdchk("tune locked", RC_TUNE_ADDR, 32'h4321);
    wr_high({5'h0, GRP_FRC});
    rdchk("group locked", OSC_CONTROL_ADDR, 32'h0280);
    rst_b <= 1'b0;
    init_cfg <= 2'h3;
    cyc(5);
    chk("active in reset", 32'h0, 32'(active_group));
    rst_b <= 1'b1;
    cyc(1);
    rdchk("strap group", OSC_CONTROL_ADDR, 32'h3300);
    report_and_stop();
  end
  // Watchdog against a hang
  initial begin
    cyc(20000);
    fails++;
    report_and_stop();
  end
endmodule : tb_top
